// ==== core/cio_core.sv ====
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cio_core import cio_pkg::*; #(
  parameter int NUM_IN        = NUM_IN_DEF,
  parameter int IN_PERIOD_CYC = (NUM_IN == 4) ? IN_PERIOD4_CYC : IN_PERIOD2_CYC,
  parameter int SLOT_CYC      = OUT_SLOT_CYC
) (
  input  wire logic                         clock_i,
  input  wire logic                         rst_n_i,
  input  wire logic                         s_axi_awvalid_i,
  output logic                              s_axi_awready_o,
  input  wire logic [7:0]                   s_axi_awaddr_i,
  input  wire logic                         s_axi_wvalid_i,
  output logic                              s_axi_wready_o,
  input  wire logic [31:0]                  s_axi_wdata_i,
  input  wire logic [3:0]                   s_axi_wstrb_i,
  output logic                              s_axi_bvalid_o,
  input  wire logic                         s_axi_bready_i,
  output logic [1:0]                        s_axi_bresp_o,
  input  wire logic                         s_axi_arvalid_i,
  output logic                              s_axi_arready_o,
  input  wire logic [7:0]                   s_axi_araddr_i,
  output logic                              s_axi_rvalid_o,
  input  wire logic                         s_axi_rready_i,
  output logic [31:0]                       s_axi_rdata_o,
  output logic [1:0]                        s_axi_rresp_o,
  output logic                              adc_start_o,
  output logic [1:0]                        adc_chan_o,
  input  wire logic                         adc_valid_i,
  input  wire logic [15:0]                  adc_data_i,
  input  wire logic                         supply_ok_i,
  input  wire logic                         self_test_fail_i,
  output logic [NUM_OUT-1:0]                dac_load_o,
  output logic [NUM_OUT-1:0][15:0]          dac_code_o
);
  logic                     awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic                     aw_held_reg, w_held_reg;
  logic [7:0]               aw_addr_reg;
  logic [31:0]              w_data_reg, rdata_reg;
  logic [3:0]               w_strb_reg;
  logic [1:0]               bresp_reg, rresp_reg;
  cio_cfg_t                 cfg_reg;
  logic                     cfg_done_reg, in_valid_reg, out_valid_reg, sweep_done_reg;
  logic [NUM_OUT-1:0][15:0] out_cnt_reg, dac_code_reg;
  logic [NUM_OUT-1:0]       dac_load_reg, served_reg;
  logic [3:0][15:0]         raw_reg, in_cnt_reg;
  logic [3:0]               open_reg;
  logic [7:0]               health_reg;
  cio_sweep_t               sweep_reg;
  logic [1:0]               ch_reg;
  logic                     adc_start_reg, out_ch_reg, fault_w, do_write_w, wr_ok_w;
  logic [20:0]              per_cnt_reg, slot_cnt_reg;
  cio_status_t              status_w;

  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o  = wready_reg;
  assign s_axi_bvalid_o  = bvalid_reg;
  assign s_axi_bresp_o   = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o  = rvalid_reg;
  assign s_axi_rdata_o   = rdata_reg;
  assign s_axi_rresp_o   = rresp_reg;
  assign adc_start_o     = adc_start_reg;
  assign adc_chan_o      = ch_reg;
  assign dac_load_o      = dac_load_reg;
  assign dac_code_o      = dac_code_reg;

  ////////////////////////////////////////////////////////////////////////////
  // status word: spare byte hard zero, unused high bits zero
  assign status_w = {8'h00, 4'h0, open_reg, health_reg};
  // outputs stay at zero point until configured and inputs are trusted
  assign fault_w = self_test_fail_i | ~supply_ok_i | ~cfg_done_reg | ~in_valid_reg;

  // health flags follow their causes every clock, no latching
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      health_reg <= 8'h0C;
    end else begin
      health_reg <= 8'h00;
      health_reg[HF_SELFTEST] <= self_test_fail_i;
      health_reg[HF_SUPPLY]   <= ~supply_ok_i;
      health_reg[HF_IN_NV]    <= ~in_valid_reg | ~supply_ok_i;
      health_reg[HF_OUT_NV]   <= fault_w | ~out_valid_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write: address and data captured in either order
  assign do_write_w = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign wr_ok_w    = (aw_addr_reg == ADDR_CFG) || (aw_addr_reg == ADDR_OUT0) ||
                      (aw_addr_reg == ADDR_OUT0 + 8'h04);
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && awready_reg) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_i;
        awready_reg <= 1'b0;
      end else if (!aw_held_reg && !bvalid_reg) begin
        awready_reg <= 1'b1;
      end
      if (s_axi_wvalid_i && wready_reg) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
        wready_reg <= 1'b0;
      end else if (!w_held_reg && !bvalid_reg) begin
        wready_reg <= 1'b1;
      end
      if (do_write_w) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_ok_w ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready_i) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // config and output counts; any config write counts as configuration
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cfg_reg      <= CFG_RESET;
      cfg_done_reg <= 1'b0;
      out_cnt_reg  <= '0;
    end else if (do_write_w) begin
      if (aw_addr_reg == ADDR_CFG) begin
        cfg_done_reg <= 1'b1;
        if (w_strb_reg[0]) cfg_reg[7:0] <= w_data_reg[7:0];
        if (w_strb_reg[1]) cfg_reg[8] <= w_data_reg[8];
      end
      for (int j = 0; j < NUM_OUT; j++) begin
        if (aw_addr_reg == ADDR_OUT0 + 8'(4 * j)) begin
          if (w_strb_reg[0]) out_cnt_reg[j][7:0]  <= w_data_reg[7:0];
          if (w_strb_reg[1]) out_cnt_reg[j][15:8] <= w_data_reg[15:8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read, one cycle to rvalid; unmapped reads give zero and slverr
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OKAY;
    end else if (s_axi_arvalid_i && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_SLVERR;
      if (s_axi_araddr_i == ADDR_STATUS) begin
        rdata_reg <= {8'h00, status_w};
        rresp_reg <= RESP_OKAY;
      end
      if (s_axi_araddr_i == ADDR_CFG) begin
        rdata_reg <= {23'h0, cfg_reg};
        rresp_reg <= RESP_OKAY;
      end
      for (int i = 0; i < 4; i++) begin
        if (s_axi_araddr_i == ADDR_IN0 + 8'(4 * i) && i < NUM_IN) begin
          rdata_reg <= {16'h0000, in_cnt_reg[i]};
          rresp_reg <= RESP_OKAY;
        end
      end
      for (int j = 0; j < NUM_OUT; j++) begin
        if (s_axi_araddr_i == ADDR_OUT0 + 8'(4 * j)) begin
          rdata_reg <= {16'h0000, out_cnt_reg[j]};
          rresp_reg <= RESP_OKAY;
        end
      end
    end else begin
      if (rvalid_reg && s_axi_rready_i) rvalid_reg <= 1'b0;
      if (!rvalid_reg) arready_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input sweep: one converter request per channel each refresh period;
  // a tick while a sweep is still running is dropped
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      per_cnt_reg    <= '0;
      sweep_reg      <= SW_IDLE;
      ch_reg         <= 2'h0;
      adc_start_reg  <= 1'b0;
      sweep_done_reg <= 1'b0;
      in_valid_reg   <= 1'b0;
      raw_reg        <= '0;
    end else begin
      per_cnt_reg    <= (per_cnt_reg == 21'(IN_PERIOD_CYC - 1)) ? '0 : per_cnt_reg + 21'h1;
      adc_start_reg  <= 1'b0;
      sweep_done_reg <= 1'b0;
      if (sweep_done_reg && cfg_done_reg) in_valid_reg <= 1'b1;
      if (~supply_ok_i) in_valid_reg <= 1'b0;
      case (sweep_reg)
        SW_IDLE: begin
          if (per_cnt_reg == 21'(IN_PERIOD_CYC - 1)) begin
            ch_reg    <= 2'h0;
            sweep_reg <= SW_START;
          end
        end
        SW_START: begin
          adc_start_reg <= 1'b1;
          sweep_reg     <= SW_WAIT;
        end
        SW_WAIT: begin
          if (adc_valid_i) begin
            raw_reg[ch_reg] <= adc_data_i;
            if (ch_reg == 2'(NUM_IN - 1)) begin
              sweep_done_reg <= 1'b1;
              sweep_reg      <= SW_IDLE;
            end else begin
              ch_reg    <= ch_reg + 2'h1;
              sweep_reg <= SW_START;
            end
          end
        end
        default: sweep_reg <= SW_IDLE;
      endcase
    end
  end

  // per-input scaling and open-loop detect; absent channels read zero
  for (genvar i = 0; i < 4; i++) begin : g_in
    logic [15:0] d_w;
    logic [16:0] s_w;
    logic [15:0] c_w;
    assign d_w = (raw_reg[i] > CODE_ZERO4) ? raw_reg[i] - CODE_ZERO4 : 16'h0000;
    assign s_w = {1'b0, d_w} + {3'b000, d_w[15:2]};
    // 4-20 mA stretches the live span, saturating above 20 mA
    assign c_w = !cfg_reg.in_rng[i] ? raw_reg[i] : (s_w[16] ? 16'hFFFF : s_w[15:0]);
    always_ff @(posedge clock_i) begin
      if (!rst_n_i || i >= NUM_IN) begin
        in_cnt_reg[i] <= 16'h0000;
        open_reg[i]   <= 1'b0;
      end else begin
        in_cnt_reg[i] <= cfg_reg.wide ? c_w : {1'b0, c_w[15:1]};
        open_reg[i]   <= in_valid_reg && cfg_reg.in_rng[i] &&
                         raw_reg[i] < CODE_OPEN_THR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output slots: each slot feeds the next enabled channel, so the full
  // cycle grows with the number of enabled outputs
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      slot_cnt_reg  <= '0;
      out_ch_reg    <= 1'b1;
      dac_load_reg  <= '0;
      served_reg    <= '0;
      out_valid_reg <= 1'b0;
    end else begin
      dac_load_reg <= '0;
      slot_cnt_reg <= (slot_cnt_reg == 21'(SLOT_CYC - 1)) ? '0 : slot_cnt_reg + 21'h1;
      if (fault_w) begin
        served_reg    <= '0;
        out_valid_reg <= 1'b0;
      end else begin
        if (slot_cnt_reg == 21'(SLOT_CYC - 1)) begin
          if (cfg_reg.out_en[~out_ch_reg]) begin
            out_ch_reg                <= ~out_ch_reg;
            dac_load_reg[~out_ch_reg] <= 1'b1;
            served_reg[~out_ch_reg]   <= 1'b1;
          end else if (cfg_reg.out_en[out_ch_reg]) begin
            dac_load_reg[out_ch_reg] <= 1'b1;
            served_reg[out_ch_reg]   <= 1'b1;
          end
        end
        if (cfg_reg.out_en != 2'h0 && (served_reg & cfg_reg.out_en) == cfg_reg.out_en)
          out_valid_reg <= 1'b1;
      end
    end
  end

  // converter codes: fault or disabled channels sit at their zero point
  for (genvar j = 0; j < NUM_OUT; j++) begin : g_out
    logic [15:0] c16_w;
    logic [31:0] p_w;
    logic [15:0] zero_w;
    assign c16_w  = cfg_reg.wide ? out_cnt_reg[j] : {out_cnt_reg[j][14:0], 1'b0};
    assign p_w    = c16_w * SCALE_4_5;
    assign zero_w = cfg_reg.out_rng[j] ? CODE_ZERO4 : 16'h0000;
    always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
        dac_code_reg[j] <= CODE_ZERO4;
      end else if (fault_w || !cfg_reg.out_en[j]) begin
        dac_code_reg[j] <= zero_w;
      end else if (dac_load_reg[j]) begin
        dac_code_reg[j] <= cfg_reg.out_rng[j] ? CODE_ZERO4 + p_w[31:16] : c16_w;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks; gap counter is only read here
  logic [20:0] gap_reg;
  logic        gap_ok_reg;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || dac_load_reg != '0) gap_reg <= 21'h1;
    else gap_reg <= gap_reg + 21'h1;
  end
  // a fault or an empty enable mask breaks the slot chain, so that gap is not judged
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || fault_w || cfg_reg.out_en == 2'h0) gap_ok_reg <= 1'b0;
    else if (dac_load_reg != '0) gap_ok_reg <= 1'b1;
  end

  chk_status_spare: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (s_axi_arvalid_i && arready_reg && s_axi_araddr_i == ADDR_STATUS)
    |=> rdata_reg[31:16] == 16'h0000 && rdata_reg[15:12] == 4'h0 && rdata_reg[7:4] == 4'h0)
    else $error("status spare bits not zero");
  chk_supply_flag: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (s_axi_arvalid_i && arready_reg && s_axi_araddr_i == ADDR_STATUS) ##1 rst_n_i
    |-> rdata_reg[HF_SUPPLY] == $past(~supply_ok_i, 2))
    else $error("supply flag wrong in status read");
  chk_open_cause: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    open_reg[2] |-> $past(cfg_reg.in_rng[2] && raw_reg[2] < CODE_OPEN_THR))
    else $error("open flag without 4-20 range and low current");
  chk_narrow_cnt: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !$past(cfg_reg.wide) |-> in_cnt_reg[1][15] == 1'b0)
    else $error("15-bit count exceeds 32767");
  chk_wide_raw: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    NUM_IN > 2 && $past(cfg_reg.wide && !cfg_reg.in_rng[2]) |-> in_cnt_reg[2] == $past(raw_reg[2]))
    else $error("16-bit 0-20 count not raw");
  chk_cfg_default: assert property (@(posedge clock_i)
    $rose(rst_n_i) |-> cfg_reg == CFG_RESET && !cfg_done_reg)
    else $error("config not at default after reset");
  chk_fault_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (fault_w && $stable(cfg_reg)) |=> dac_code_reg[0] ==
    ($past(cfg_reg.out_rng[0]) ? CODE_ZERO4 : 16'h0000))
    else $error("fault output not at zero point");
  chk_slot_gap: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (dac_load_reg != '0 && gap_ok_reg) |-> gap_reg == 21'(SLOT_CYC))
    else $error("output slot spacing wrong");
  chk_period_wrap: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    per_cnt_reg == 21'(IN_PERIOD_CYC - 1) |=> per_cnt_reg == '0 ##1 per_cnt_reg == 21'h1)
    else $error("input period counter wrong");
  chk_chan_range: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    adc_start_reg |-> ch_reg <= 2'(NUM_IN - 1))
    else $error("converter channel beyond variant");
  chk_nv_reset: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !$past(in_valid_reg) |-> health_reg[HF_IN_NV] && health_reg[HF_OUT_NV])
    else $error("not-valid flag clear before first cycle");
  chk_flag_live: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $fell(self_test_fail_i) ##1 rst_n_i |-> !health_reg[HF_SELFTEST])
    else $error("self-test flag did not clear");

  cov_write: cover property (@(posedge clock_i) do_write_w && aw_addr_reg == ADDR_CFG);
  cov_sweep: cover property (@(posedge clock_i) sweep_done_reg && cfg_done_reg);
  cov_load1: cover property (@(posedge clock_i) dac_load_reg[1] && !fault_w);
  cov_open:  cover property (@(posedge clock_i) $rose(open_reg[2]));
endmodule
`default_nettype wire

// ==== core/cio_pkg.sv ====
package cio_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS  = 40;
  localparam int IN_PERIOD2_US  = 30_000;
  localparam int IN_PERIOD4_US  = 45_000;
  localparam int OUT_SLOT_US    = 2_500;
  localparam int IN_PERIOD2_CYC = IN_PERIOD2_US * 1000 / CLK_PERIOD_NS;
  localparam int IN_PERIOD4_CYC = IN_PERIOD4_US * 1000 / CLK_PERIOD_NS;
  localparam int OUT_SLOT_CYC   = OUT_SLOT_US * 1000 / CLK_PERIOD_NS;
  localparam int NUM_IN_DEF     = 4;
  localparam int NUM_OUT        = 2;
  // register byte offsets
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CFG    = 8'h04;
  localparam logic [7:0] ADDR_IN0    = 8'h10;
  localparam logic [7:0] ADDR_OUT0   = 8'h20;
  // health byte bit positions
  localparam int HF_SELFTEST = 0;
  localparam int HF_SUPPLY   = 1;
  localparam int HF_IN_NV    = 2;
  localparam int HF_OUT_NV   = 3;
  // converter codes, 16-bit full scale equals 20 mA
  localparam logic [15:0] CODE_ZERO4    = 16'h3333;
  localparam logic [15:0] CODE_OPEN_THR = 16'h3000;
  localparam logic [15:0] SCALE_4_5     = 16'hCCCD;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // configuration word, wide in bit 0
  typedef struct packed {
    logic [1:0] out_en;
    logic [1:0] out_rng;
    logic [3:0] in_rng;
    logic       wide;
  } cio_cfg_t;
  localparam cio_cfg_t CFG_RESET = 9'h1FE;
  // 24-bit status space
  typedef struct packed {
    logic [7:0] spare;
    logic [7:0] open;
    logic [7:0] health;
  } cio_status_t;
  typedef enum logic [1:0] {
    SW_IDLE  = 2'b00,
    SW_START = 2'b01,
    SW_WAIT  = 2'b10
  } cio_sweep_t;
endpackage

// ==== tb/cio_adc_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// converter stand-in: odd channels answer slowly, even ones promptly
module cio_adc_model (
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic             start_i,
  input  wire logic [1:0]       chan_i,
  input  wire logic [3:0][15:0] codes_i,
  output logic                  valid_o,
  output logic [15:0]           data_o
);
  logic       busy_reg;
  logic [1:0] chan_reg;
  logic [3:0] wait_reg;
  ////////////////////////////////////////////////////////////////
  // one conversion per start pulse; data only means something with valid,
  // otherwise it toggles so a design that samples late sees garbage
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      busy_reg <= 1'b0;
      chan_reg <= 2'h0;
      wait_reg <= 4'h0;
      valid_o  <= 1'b0;
      data_o   <= 16'h0000;
    end else begin
      valid_o <= 1'b0;
      data_o  <= ~data_o;
      if (start_i) begin
        busy_reg <= 1'b1;
        chan_reg <= chan_i;
        wait_reg <= chan_i[0] ? 4'h6 : 4'h0;
      end else if (busy_reg && wait_reg == 4'h0) begin
        busy_reg <= 1'b0;
        valid_o  <= 1'b1;
        data_o   <= codes_i[chan_reg];
      end else if (busy_reg) begin
        wait_reg <= wait_reg - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench import cio_pkg::*;;
  localparam int PER = 200;
  localparam int SLOT = 50;
  logic clock_i, rst_n_i, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, adc_start, adc_valid, supply_ok, st_fail;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, adc_chan, rs, dac_load;
  logic [15:0] adc_data;
  logic [1:0][15:0] dac_code;
  logic [3:0][15:0] codes;
  int n_errors, n_compared, n;
  cio_core #(.NUM_IN(4), .IN_PERIOD_CYC(PER), .SLOT_CYC(SLOT)) dut_u (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_araddr_i(araddr),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .adc_start_o(adc_start), .adc_chan_o(adc_chan),
    .adc_valid_i(adc_valid), .adc_data_i(adc_data), .supply_ok_i(supply_ok),
    .self_test_fail_i(st_fail), .dac_load_o(dac_load), .dac_code_o(dac_code));
  cio_adc_model adc_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .start_i(adc_start),
    .chan_i(adc_chan), .codes_i(codes), .valid_o(adc_valid), .data_o(adc_data));
  ////////////////////////////////////////////////////////////////
  // clock at 25 MHz
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  ////////////////////////////////////////////////////////////////
  // bus write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= 4'hF; bready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (!aw && awready) begin aw = 1'b1; awvalid <= 1'b0; end
      if (!w && wready) begin w = 1'b1; wvalid <= 1'b0; end
    end while (!(aw && w && bvalid));
    r = bresp;
    bready <= 1'b0;
    @(posedge clock_i);
  endtask
  // bus read; rready held until the answer is sampled
  task automatic rdw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar;
    ar = 1'b0;
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (!ar && arready) begin ar = 1'b1; arvalid <= 1'b0; end
    end while (!(ar && rvalid));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clock_i);
  endtask
  // read and compare data with an OKAY answer
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rdw(a, rd, rs);
    `CHK(rd, e)
    `CHK(rs, RESP_OKAY)
  endtask
  // cycles between two consecutive pulses of a sampled strobe
  task automatic gap(input int sel, output int c);
    c = 0;
    do @(posedge clock_i); while (!(sel < 2 ? dac_load[sel] : adc_start && adc_chan == 2'h0));
    do begin @(posedge clock_i); c++; end
    while (!(sel < 2 ? dac_load[sel] : adc_start && adc_chan == 2'h0));
  endtask
  task automatic conclude();
    if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog: the whole sequence needs a few thousand cycles
  initial begin
    repeat (40000) @(posedge clock_i);
    n_errors++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////
  // main sequence; the bench itself checks not-valid flags before using counts
  initial begin
    n_errors = 0; n_compared = 0; rst_n_i = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, st_fail} = 6'h00;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hF; supply_ok = 1'b1;
    codes = {16'h8000, 16'h2000, 16'hFFFF, 16'h3333};
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    rchk(ADDR_STATUS, 32'h0000000C);
    rchk(ADDR_CFG, 32'h000001FE);
    `CHK(dac_code[0], CODE_ZERO4)
    rdw(8'h40, rd, rs);
    `CHK({rd, rs}, {32'h0, RESP_SLVERR})
    wr(ADDR_STATUS, 32'hFF, rs);
    `CHK(rs, RESP_SLVERR)
    wr(ADDR_IN0, 32'hFF, rs);
    `CHK(rs, RESP_SLVERR)
    // 15-bit default, all 4-20: one channel below the open threshold
    wr(ADDR_CFG, 32'h1FE, rs);
    repeat (2 * PER + 50) @(posedge clock_i);
    rchk(ADDR_STATUS, 32'h00000400);
    rchk(ADDR_IN0, 32'h0);
    rchk(ADDR_IN0 + 8'h04, 32'h7FFF);
    rchk(ADDR_IN0 + 8'h08, 32'h0);
    rchk(ADDR_IN0 + 8'h0C, 32'h3000);
    // 16-bit mode, channel 2 moved to 0-20: open flag must drop
    wr(ADDR_CFG, 32'h1F7, rs);
    repeat (2 * PER + 50) @(posedge clock_i);
    rchk(ADDR_STATUS, 32'h0);
    rchk(ADDR_IN0 + 8'h04, 32'hFFFF);
    rchk(ADDR_IN0 + 8'h08, 32'h2000);
    rchk(ADDR_IN0 + 8'h0C, 32'h6000);
    // outputs: 4-20 full scale and 0-20 half scale
    wr(ADDR_CFG, 32'h1B7, rs);
    wr(ADDR_OUT0, 32'hFFFF, rs);
    wr(ADDR_OUT0 + 8'h04, 32'h8000, rs);
    repeat (2 * SLOT + 5) @(posedge clock_i);
    `CHK(dac_code, {16'h8000, 16'hFFFF})
    gap(0, n);
    `CHK(n, 2 * SLOT)
    gap(2, n);
    `CHK(n, PER)
    // supply loss then self-test failure; flags follow the condition
    supply_ok <= 1'b0;
    repeat (2 * SLOT + 5) @(posedge clock_i);
    rdw(ADDR_STATUS, rd, rs);
    `CHK(rd[2:0], 3'h6)
    `CHK(dac_code, {16'h0000, CODE_ZERO4})
    supply_ok <= 1'b1;
    st_fail <= 1'b1;
    repeat (2 * PER + 50) @(posedge clock_i);
    rdw(ADDR_STATUS, rd, rs);
    `CHK({rd[31:16], rd[1:0]}, 18'h00001)
    `CHK(dac_code, {16'h0000, CODE_ZERO4})
    st_fail <= 1'b0;
    repeat (2 * PER + 50) @(posedge clock_i);
    rchk(ADDR_STATUS, 32'h0);
    `CHK(dac_code, {16'h8000, 16'hFFFF})
    // only the first output enabled: its slot comes every SLOT cycles
    wr(ADDR_CFG, 32'h0B7, rs);
    gap(0, n);
    gap(0, n);
    `CHK(n, SLOT)
    conclude();
  end
endmodule
`default_nettype wire
